/* File: rtl/dat_pkg.sv */
package dat_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [6:0] DAT_OFF_I_AUX_MAG_LOW   = 7'h42;
    localparam logic [6:0] DAT_OFF_I_AUX_CTRL      = 7'h43;
    localparam logic [6:0] DAT_OFF_Q_FS_LOW        = 7'h44;
    localparam logic [6:0] DAT_OFF_Q_CONV_CTRL     = 7'h45;
    localparam logic [6:0] DAT_OFF_Q_AUX_MAG_LOW   = 7'h46;
    localparam logic [6:0] DAT_OFF_Q_AUX_CTRL      = 7'h47;
    localparam logic [6:0] DAT_OFF_MEAS_SETUP      = 7'h48;
    localparam logic [6:0] DAT_OFF_TEMP_LOW        = 7'h49;
    localparam logic [6:0] DAT_OFF_TEMP_HIGH       = 7'h4A;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int DAT_BIT_AUX_SIGN   = 7;
    localparam int DAT_BIT_AUX_SINK   = 6;
    localparam int DAT_BIT_AUX_SLEEP  = 5;
    localparam int DAT_BIT_CONV_SLEEP = 7;
    localparam int DAT_HI_MSB         = 1;
    localparam int DAT_MEAS_FS_LSB    = 4;
    localparam int DAT_MEAS_REF_LSB   = 1;
    localparam int DAT_MEAS_CAP_BIT   = 0;

    // implemented bits, all others read as zero
    localparam logic [7:0] DAT_MASK_AUX_CTRL  = 8'hE3;
    localparam logic [7:0] DAT_MASK_CONV_CTRL = 8'h83;
    localparam logic [7:0] DAT_MASK_MEAS      = 8'h7F;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0]  DAT_RST_AUX_MAG_LOW = 8'h00;
    localparam logic [7:0]  DAT_RST_AUX_CTRL    = 8'h00;
    localparam logic [7:0]  DAT_RST_Q_FS_LOW    = 8'hF9;
    localparam logic [7:0]  DAT_RST_CONV_CTRL   = 8'h01;
    localparam logic [7:0]  DAT_RST_MEAS        = 8'h02;
    localparam logic [15:0] DAT_RST_TEMP        = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////////
    // serial port framing
    localparam logic [3:0] DAT_SPI_LAST_BIT = 4'h7;
    localparam int         DAT_SPI_RW_BIT   = 7;

    typedef enum logic [1:0] {
        DAT_SPI_INSTR = 2'b00,
        DAT_SPI_DATA  = 2'b01,
        DAT_SPI_DONE  = 2'b10
    } dat_spi_state_t;

endpackage : dat_pkg

/* File: rtl/dat_reg_if.sv */
`timescale 1ns/1ps
interface dat_reg_if;
    logic       wr_en;
    logic       rd_en;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport master (output wr_en, output rd_en, output addr, output wdata, input rdata);
    modport watch  (input rd_en, input addr);
endinterface : dat_reg_if

/* File: rtl/dat_spi_slave.sv */
`timescale 1ns/1ps
module dat_spi_slave
    import dat_pkg::*;
(
    // clock and reset
    input  wire logic   clk,
    input  wire logic   rst_n,
    // serial port pins
    input  wire logic   spi_cs_n,
    input  wire logic   spi_sclk,
    input  wire logic   spi_sdi,
    output logic        spi_sdo,
    output logic        spi_sdo_oe,
    // register access
    dat_reg_if.master   bus
);
    dat_spi_state_t state_q;
    logic           sclk_q;
    logic [3:0]     cnt_q;
    logic [6:0]     in_sh_q;
    logic [7:0]     out_sh_q;
    logic           read_q;
    logic           wr_q;
    logic           rd_q;
    logic [6:0]     addr_q;
    logic [7:0]     wdata_q;

    wire       rise      = spi_sclk & ~sclk_q & ~spi_cs_n;
    wire       fall      = ~spi_sclk & sclk_q & ~spi_cs_n;
    wire [7:0] byte_in   = {in_sh_q, spi_sdi};
    wire       last_bit  = rise & (cnt_q == DAT_SPI_LAST_BIT);
    wire       instr_end = last_bit & (state_q == DAT_SPI_INSTR);
    wire       data_end  = last_bit & (state_q == DAT_SPI_DATA);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= DAT_SPI_INSTR;
            sclk_q  <= 1'b0;
            cnt_q   <= 4'h0;
            in_sh_q <= 7'h00;
            read_q  <= 1'b0;
            addr_q  <= 7'h00;
            wdata_q <= 8'h00;
            wr_q    <= 1'b0;
            rd_q    <= 1'b0;
        end else begin
            sclk_q <= spi_sclk;
            wr_q   <= data_end & ~read_q;
            rd_q   <= instr_end & byte_in[DAT_SPI_RW_BIT];
            if (spi_cs_n) begin
                state_q <= DAT_SPI_INSTR;
                cnt_q   <= 4'h0;
            end else if (rise) begin
                in_sh_q <= byte_in[6:0];
                cnt_q   <= last_bit ? 4'h0 : cnt_q + 4'h1;
                if (instr_end) begin
                    state_q <= DAT_SPI_DATA;
                    read_q  <= byte_in[DAT_SPI_RW_BIT];
                    addr_q  <= byte_in[6:0];
                end
                if (data_end) begin
                    state_q <= DAT_SPI_DONE;
                    wdata_q <= byte_in;
                end
            end
        end
    end

    // read data is ready one clock after rd_en, well before the next falling edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            spi_sdo    <= 1'b0;
            out_sh_q   <= 8'h00;
            spi_sdo_oe <= 1'b0;
        end else begin
            spi_sdo_oe <= ~spi_cs_n & read_q & (state_q == DAT_SPI_DATA);
            if (fall && read_q && state_q == DAT_SPI_DATA) begin
                spi_sdo  <= (cnt_q == 4'h0) ? bus.rdata[7] : out_sh_q[7];
                out_sh_q <= (cnt_q == 4'h0) ? {bus.rdata[6:0], 1'b0} : {out_sh_q[6:0], 1'b0};
            end
        end
    end

    assign bus.wr_en = wr_q;
    assign bus.rd_en = rd_q;
    assign bus.addr  = addr_q;
    assign bus.wdata = wdata_q;

endmodule : dat_spi_slave

/* File: rtl/dat_temp_hold.sv */
`timescale 1ns/1ps
module dat_temp_hold
    import dat_pkg::*;
#(
    parameter int TEMP_W = 16
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // measurement result
    input  wire logic [TEMP_W-1:0] temp_result,
    input  wire logic              temp_valid,
    // register access
    dat_reg_if.watch               bus,
    output logic [TEMP_W-1:0]      value_q,
    output logic [7:0]             high_shadow_q
);
    if (TEMP_W != 16) begin : g_chk
        $error("dat_temp_hold: TEMP_W must be 16");
    end

    // low byte read freezes the high byte so a two-byte read is coherent
    wire low_read = bus.rd_en & (bus.addr == DAT_OFF_TEMP_LOW);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            value_q       <= DAT_RST_TEMP;
            high_shadow_q <= DAT_RST_TEMP[15:8];
        end else begin
            if (temp_valid) begin
                value_q <= temp_result;
            end
            if (low_read) begin
                high_shadow_q <= value_q[15:8];
            end
        end
    end

endmodule : dat_temp_hold

/* File: rtl/dat_cfg_regs.sv */
`timescale 1ns/1ps
// Functional notes
// - I aux control bit 7 steers I aux current: 0 positive, 1 negative output.
// - I aux control bit 6: 0 sources current, 1 sinks current.
// - I aux control bit 5 puts I aux source to sleep; resets 0.
// - I aux magnitude is 10 bits: low byte at 0x42, top bits in 0x43[1:0].
// - Q full-scale is 10 bits: low byte 0x44, top bits 0x45[1:0].
// - Q control bit 7 puts Q converter into fast wake-up sleep; resets 0.
// - Q aux magnitude is 10 bits: low byte 0x46, top bits 0x47[1:0].
// - Q aux control bit 7 steers Q aux current: 0 positive, 1 negative.
// - Q aux control bit 6: 0 sources current, 1 sinks current.
// - Q aux control bit 5 puts Q aux source to sleep; resets 0.
// - Setup register bits 6:4 set measurement full-scale current; resets 0.
// - Setup register bits 3:1 set measurement reference current; resets 1.
// - Setup register bit 0 selects small or doubled measurement capacitor.
// - 16-bit die temperature reads at 0x49 low and 0x4A high.
module dat_cfg_regs
    import dat_pkg::*;
#(
    parameter int TEMP_W = 16
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // serial port pins
    input  wire logic              spi_cs_n,
    input  wire logic              spi_sclk,
    input  wire logic              spi_sdi,
    output logic                   spi_sdo,
    output logic                   spi_sdo_oe,
    // temperature measurement result
    input  wire logic [TEMP_W-1:0] temp_result,
    input  wire logic              temp_valid,
    // I auxiliary source
    output logic [9:0]             i_aux_magnitude,
    output logic                   i_aux_to_negative,
    output logic                   i_aux_sink,
    output logic                   i_aux_sleep,
    // Q main converter
    output logic [9:0]             q_fullscale,
    output logic                   q_conv_sleep,
    // Q auxiliary source
    output logic [9:0]             q_aux_magnitude,
    output logic                   q_aux_to_negative,
    output logic                   q_aux_sink,
    output logic                   q_aux_sleep,
    // measurement converter
    output logic [2:0]             meas_fs_current,
    output logic [2:0]             meas_ref_current,
    output logic                   meas_cap_double
);
    if (TEMP_W != 16) begin : g_chk
        $error("dat_cfg_regs: TEMP_W must be 16");
    end

    function automatic logic hit(input logic [6:0] addr, input logic [6:0] off);
        hit = (addr == off);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////////////
    // serial port and temperature holder

    dat_reg_if reg_bus ();

    logic [TEMP_W-1:0] temp_value;
    logic [7:0]        temp_high_shadow;

    dat_spi_slave u_spi (
        .clk        (clk),
        .rst_n      (rst_n),
        .spi_cs_n   (spi_cs_n),
        .spi_sclk   (spi_sclk),
        .spi_sdi    (spi_sdi),
        .spi_sdo    (spi_sdo),
        .spi_sdo_oe (spi_sdo_oe),
        .bus        (reg_bus.master)
    );

    dat_temp_hold #(
        .TEMP_W (TEMP_W)
    ) u_temp (
        .clk           (clk),
        .rst_n         (rst_n),
        .temp_result   (temp_result),
        .temp_valid    (temp_valid),
        .bus           (reg_bus.watch),
        .value_q       (temp_value),
        .high_shadow_q (temp_high_shadow)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // auxiliary sources, channel 0 is I and channel 1 is Q

    localparam logic [6:0] AUX_LOW_OFF  [2] = '{DAT_OFF_I_AUX_MAG_LOW, DAT_OFF_Q_AUX_MAG_LOW};
    localparam logic [6:0] AUX_CTRL_OFF [2] = '{DAT_OFF_I_AUX_CTRL, DAT_OFF_Q_AUX_CTRL};

    logic [7:0] aux_low_q  [2];
    logic [7:0] aux_ctrl_q [2];

    for (genvar ch = 0; ch < 2; ch++) begin : g_aux
        wire wr_low  = reg_bus.wr_en & hit(reg_bus.addr, AUX_LOW_OFF[ch]);
        wire wr_ctrl = reg_bus.wr_en & hit(reg_bus.addr, AUX_CTRL_OFF[ch]);

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                aux_low_q[ch]  <= DAT_RST_AUX_MAG_LOW;
                aux_ctrl_q[ch] <= DAT_RST_AUX_CTRL;
            end else begin
                if (wr_low) begin
                    aux_low_q[ch] <= reg_bus.wdata;
                end
                if (wr_ctrl) begin
                    aux_ctrl_q[ch] <= reg_bus.wdata & DAT_MASK_AUX_CTRL;
                end
            end
        end
    end

    // sign, direction, sleep and top magnitude bits
    assign i_aux_magnitude   = {aux_ctrl_q[0][DAT_HI_MSB:0], aux_low_q[0]};
    assign i_aux_to_negative = aux_ctrl_q[0][DAT_BIT_AUX_SIGN];
    assign i_aux_sink        = aux_ctrl_q[0][DAT_BIT_AUX_SINK];
    assign i_aux_sleep       = aux_ctrl_q[0][DAT_BIT_AUX_SLEEP];
    assign q_aux_magnitude   = {aux_ctrl_q[1][DAT_HI_MSB:0], aux_low_q[1]};
    assign q_aux_to_negative = aux_ctrl_q[1][DAT_BIT_AUX_SIGN];
    assign q_aux_sink        = aux_ctrl_q[1][DAT_BIT_AUX_SINK];
    assign q_aux_sleep       = aux_ctrl_q[1][DAT_BIT_AUX_SLEEP];

    ////////////////////////////////////////////////////////////////////////////////
    // Q converter and measurement setup

    logic [7:0] q_fs_low_q;
    logic [7:0] q_ctrl_q;
    logic [7:0] meas_q;

    wire wr_fs_low = reg_bus.wr_en & hit(reg_bus.addr, DAT_OFF_Q_FS_LOW);
    wire wr_q_ctrl = reg_bus.wr_en & hit(reg_bus.addr, DAT_OFF_Q_CONV_CTRL);
    wire wr_meas   = reg_bus.wr_en & hit(reg_bus.addr, DAT_OFF_MEAS_SETUP);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q_fs_low_q <= DAT_RST_Q_FS_LOW;
            q_ctrl_q   <= DAT_RST_CONV_CTRL;
            meas_q     <= DAT_RST_MEAS;
        end else begin
            if (wr_fs_low) begin
                q_fs_low_q <= reg_bus.wdata;
            end
            if (wr_q_ctrl) begin
                q_ctrl_q <= reg_bus.wdata & DAT_MASK_CONV_CTRL;
            end
            if (wr_meas) begin
                meas_q <= reg_bus.wdata & DAT_MASK_MEAS;
            end
        end
    end

    assign q_fullscale      = {q_ctrl_q[DAT_HI_MSB:0], q_fs_low_q};
    assign q_conv_sleep     = q_ctrl_q[DAT_BIT_CONV_SLEEP];
    assign meas_fs_current  = meas_q[DAT_MEAS_FS_LSB +: 3];
    assign meas_ref_current = meas_q[DAT_MEAS_REF_LSB +: 3];
    assign meas_cap_double  = meas_q[DAT_MEAS_CAP_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // read-back, unmapped offsets read zero; temperature bytes take no writes

    logic [7:0] rdata_q;

    wire [6:0] ra = reg_bus.addr;
    wire [7:0] rdata_d =
        hit(ra, DAT_OFF_I_AUX_MAG_LOW) ? aux_low_q[0]          :
        hit(ra, DAT_OFF_I_AUX_CTRL)    ? aux_ctrl_q[0]         :
        hit(ra, DAT_OFF_Q_FS_LOW)      ? q_fs_low_q            :
        hit(ra, DAT_OFF_Q_CONV_CTRL)   ? q_ctrl_q              :
        hit(ra, DAT_OFF_Q_AUX_MAG_LOW) ? aux_low_q[1]          :
        hit(ra, DAT_OFF_Q_AUX_CTRL)    ? aux_ctrl_q[1]         :
        hit(ra, DAT_OFF_MEAS_SETUP)    ? meas_q                :
        hit(ra, DAT_OFF_TEMP_LOW)      ? temp_value[7:0]       :
        hit(ra, DAT_OFF_TEMP_HIGH)     ? temp_high_shadow      :
                                         8'h00;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (reg_bus.rd_en) begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_bus.rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_wr(logic [6:0] off);
        reg_bus.wr_en && reg_bus.addr == off;
    endsequence

    sequence s_rd(logic [6:0] off);
        reg_bus.rd_en && reg_bus.addr == off;
    endsequence

    a_i_aux_ctrl: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_wr(DAT_OFF_I_AUX_CTRL) |=> i_aux_to_negative == $past(reg_bus.wdata[7])
            && i_aux_sink == $past(reg_bus.wdata[6]) && i_aux_sleep == $past(reg_bus.wdata[5]))
        else $error("I aux control bits not taken from write");

    a_i_aux_mag: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_wr(DAT_OFF_I_AUX_MAG_LOW) |=> i_aux_magnitude[7:0] == $past(reg_bus.wdata)
            && i_aux_magnitude[9:8] == $past(i_aux_magnitude[9:8]))
        else $error("I aux magnitude low byte wrong");

    a_q_fullscale: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_wr(DAT_OFF_Q_CONV_CTRL) |=> q_fullscale[9:8] == $past(reg_bus.wdata[1:0])
            && q_fullscale[7:0] == $past(q_fullscale[7:0]))
        else $error("Q full-scale top bits wrong");

    a_q_sleep: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_wr(DAT_OFF_Q_CONV_CTRL) |=> q_conv_sleep == $past(reg_bus.wdata[7]))
        else $error("Q converter sleep not taken");

    a_q_aux_ctrl: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_wr(DAT_OFF_Q_AUX_CTRL) |=> q_aux_magnitude[9:8] == $past(reg_bus.wdata[1:0])
            && q_aux_to_negative == $past(reg_bus.wdata[7])
            && q_aux_sink == $past(reg_bus.wdata[6]) && q_aux_sleep == $past(reg_bus.wdata[5])
            && i_aux_sleep == $past(i_aux_sleep))
        else $error("Q aux control bits wrong");

    a_meas_setup: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_wr(DAT_OFF_MEAS_SETUP) |=> meas_fs_current == $past(reg_bus.wdata[6:4])
            && meas_ref_current == $past(reg_bus.wdata[3:1])
            && meas_cap_double == $past(reg_bus.wdata[0]))
        else $error("measurement setup fields wrong");

    a_reset_values: assert property (
        @(posedge clk)
        !rst_n |=> q_fullscale == 10'h1F9 && !q_conv_sleep && meas_ref_current == 3'h1
            && meas_fs_current == 3'h0 && !i_aux_sleep && !q_aux_sleep)
        else $error("reset values wrong");

    // low byte read returns the live byte and freezes the high byte beside it
    a_temp_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_rd(DAT_OFF_TEMP_LOW) |=> temp_high_shadow == $past(temp_value[15:8])
            && rdata_q == $past(temp_value[7:0]))
        else $error("temperature high byte not coherent");

    a_temp_high: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_rd(DAT_OFF_TEMP_HIGH) |=> rdata_q == $past(temp_high_shadow))
        else $error("temperature high byte read wrong");

    a_unused_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        reg_bus.rd_en && (ra == DAT_OFF_I_AUX_CTRL || ra == DAT_OFF_Q_AUX_CTRL)
            |=> rdata_q[4:2] == 3'h0)
        else $error("unused control bits read nonzero");

    a_conv_unused: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_rd(DAT_OFF_Q_CONV_CTRL) |=> rdata_q[6:2] == 5'h00)
        else $error("unused Q control bits read nonzero");

    a_meas_unused: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_rd(DAT_OFF_MEAS_SETUP) |=> !rdata_q[7])
        else $error("unused setup bit reads nonzero");

    a_temp_no_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        reg_bus.wr_en && (ra == DAT_OFF_TEMP_LOW || ra == DAT_OFF_TEMP_HIGH) && !temp_valid
            |=> temp_value == $past(temp_value) && q_fullscale == $past(q_fullscale))
        else $error("temperature write had an effect");

    a_q_fs_low: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_wr(DAT_OFF_Q_FS_LOW) |=> q_fullscale[7:0] == $past(reg_bus.wdata)
            && q_fullscale[9:8] == $past(q_fullscale[9:8]))
        else $error("Q full-scale low byte wrong");

    a_q_aux_mag: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_wr(DAT_OFF_Q_AUX_MAG_LOW) |=> q_aux_magnitude[7:0] == $past(reg_bus.wdata)
            && q_aux_magnitude[9:8] == $past(q_aux_magnitude[9:8])
            && i_aux_magnitude == $past(i_aux_magnitude))
        else $error("Q aux magnitude low byte wrong");

    a_i_aux_top: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_wr(DAT_OFF_I_AUX_CTRL) |=> i_aux_magnitude[9:8] == $past(reg_bus.wdata[1:0])
            && q_aux_magnitude == $past(q_aux_magnitude))
        else $error("I aux magnitude top bits wrong");

    // a read must never disturb a code that drives the analog side
    a_read_stable: assert property (
        @(posedge clk) disable iff (!rst_n)
        reg_bus.rd_en |=> $stable(i_aux_magnitude) && $stable(q_aux_magnitude)
            && $stable(q_fullscale))
        else $error("read changed a magnitude code");

endmodule : dat_cfg_regs

/* File: dv/tb.sv */
`timescale 1ns/1ps
module tb;
    import dat_pkg::*;

    // clock, reset and pins
    logic        clk;
    logic        rst_n;
    logic        spi_cs_n;
    logic        spi_sclk;
    logic        spi_sdi;
    logic        spi_sdo;
    logic        spi_sdo_oe;
    logic [15:0] temp_result;
    logic        temp_valid;
    // decoded outputs
    logic [9:0]  i_aux_magnitude;
    logic        i_aux_to_negative;
    logic        i_aux_sink;
    logic        i_aux_sleep;
    logic [9:0]  q_fullscale;
    logic        q_conv_sleep;
    logic [9:0]  q_aux_magnitude;
    logic        q_aux_to_negative;
    logic        q_aux_sink;
    logic        q_aux_sleep;
    logic [2:0]  meas_fs_current;
    logic [2:0]  meas_ref_current;
    logic        meas_cap_double;
    int          miscompares;
    int          check_count;

    dat_cfg_regs #(.TEMP_W(16)) i_dat_cfg_regs (
        .clk(clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi),
        .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .temp_result(temp_result), .temp_valid(temp_valid),
        .i_aux_magnitude(i_aux_magnitude), .i_aux_to_negative(i_aux_to_negative), .i_aux_sink(i_aux_sink),
        .i_aux_sleep(i_aux_sleep), .q_fullscale(q_fullscale), .q_conv_sleep(q_conv_sleep),
        .q_aux_magnitude(q_aux_magnitude), .q_aux_to_negative(q_aux_to_negative), .q_aux_sink(q_aux_sink),
        .q_aux_sleep(q_aux_sleep), .meas_fs_current(meas_fs_current), .meas_ref_current(meas_ref_current),
        .meas_cap_double(meas_cap_double)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic conclude;
        $display("counts: %0d checks, %0d mismatches", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    ////////////////////////////////////////////////////////////////////////////////
    // one whole frame; sclk phases of 3 clk so read data is ready at the first fall
    task automatic xfer(input logic [7:0] ins, input logic [7:0] wd, output logic [7:0] rd);
        logic [15:0] sh;
        sh = {ins, wd};
        rd = 8'h00;
        spi_cs_n = 1'b0;
        for (int i = 0; i < 16; i++) begin
            spi_sdi = sh[15-i];
            spi_sclk = 1'b0;
            repeat (3) @(posedge clk);
            #1;
            if (i >= 8) rd = {rd[6:0], spi_sdo};
            if (i == 8) chk("sdo_oe in data", {15'h0, ins[7]}, {15'h0, spi_sdo_oe});
            spi_sclk = 1'b1;
            repeat (3) @(posedge clk);
            #1;
        end
        spi_sclk = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        spi_cs_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("sdo_oe idle", 16'h0000, {15'h0, spi_sdo_oe});
    endtask : xfer

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] dummy;
        xfer({1'b0, a}, d, dummy);
    endtask : wr

    task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] v;
        xfer({1'b1, a}, 8'h00, v);
        chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, v});
    endtask : rdchk

    function automatic logic [12:0] aux_view(input int ch);
        if (ch == 0) return {i_aux_to_negative, i_aux_sink, i_aux_sleep, i_aux_magnitude};
        return {q_aux_to_negative, q_aux_sink, q_aux_sleep, q_aux_magnitude};
    endfunction : aux_view

    function automatic logic [6:0] meas_view();
        return {meas_fs_current, meas_ref_current, meas_cap_double};
    endfunction : meas_view

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk("q_fullscale", 16'h01F9, {6'h0, q_fullscale});
        chk("meas", 16'h0002, {9'h0, meas_view()});
        chk("aux", 16'h0000, {3'h0, aux_view(0)});
        chk("aux q", 16'h0000, {3'h0, aux_view(1)});
        chk("conv sleep", 16'h0000, {15'h0, q_conv_sleep});
        rdchk(DAT_OFF_I_AUX_CTRL, 8'h00);
        rdchk(DAT_OFF_Q_FS_LOW, 8'hF9);
        rdchk(DAT_OFF_Q_CONV_CTRL, 8'h01);
        rdchk(DAT_OFF_Q_AUX_CTRL, 8'h00);
        rdchk(DAT_OFF_MEAS_SETUP, 8'h02);
    endtask : t_reset

    task automatic t_aux(input int ch, input logic [6:0] lo, input logic [6:0] hi);
        wr(lo, 8'hA5);
        wr(hi, 8'hFF);
        chk("aux all set", 16'h1FA5, {3'h0, aux_view(ch)});
        rdchk(hi, 8'hE3);
        rdchk(lo, 8'hA5);
        wr(hi, 8'h40);
        chk("aux sink only", 16'h08A5, {3'h0, aux_view(ch)});
        wr(hi, 8'h81);
        chk("aux negative", 16'h11A5, {3'h0, aux_view(ch)});
        wr(hi, 8'h20);
        chk("aux sleep", 16'h04A5, {3'h0, aux_view(ch)});
        wr(lo, 8'h00);
        wr(hi, 8'h00);
        chk("aux zero", 16'h0000, {3'h0, aux_view(ch)});
    endtask : t_aux

    task automatic t_conv;
        wr(DAT_OFF_Q_FS_LOW, 8'h00);
        wr(DAT_OFF_Q_CONV_CTRL, 8'h80);
        chk("fs low end", 16'h0000, {6'h0, q_fullscale});
        chk("conv sleep on", 16'h0001, {15'h0, q_conv_sleep});
        wr(DAT_OFF_Q_FS_LOW, 8'hFF);
        wr(DAT_OFF_Q_CONV_CTRL, 8'h7F);
        chk("fs top end", 16'h03FF, {6'h0, q_fullscale});
        chk("conv sleep off", 16'h0000, {15'h0, q_conv_sleep});
        rdchk(DAT_OFF_Q_CONV_CTRL, 8'h03);
    endtask : t_conv

    task automatic t_meas;
        wr(DAT_OFF_MEAS_SETUP, 8'h5B);
        chk("meas 5b", 16'h005B, {9'h0, meas_view()});
        wr(DAT_OFF_MEAS_SETUP, 8'hFF);
        chk("meas ff", 16'h007F, {9'h0, meas_view()});
        rdchk(DAT_OFF_MEAS_SETUP, 8'h7F);
        wr(DAT_OFF_MEAS_SETUP, 8'h00);
        chk("meas 00", 16'h0000, {9'h0, meas_view()});
    endtask : t_meas

    task automatic t_temp;
        temp_result = 16'hC422;
        temp_valid = 1'b1;
        @(posedge clk);
        #1;
        temp_valid = 1'b0;
        rdchk(DAT_OFF_TEMP_LOW, 8'h22);
        temp_result = 16'hD8A8;
        temp_valid = 1'b1;
        @(posedge clk);
        #1;
        temp_valid = 1'b0;
        // high byte stays paired with the low byte already read
        rdchk(DAT_OFF_TEMP_HIGH, 8'hC4);
        wr(DAT_OFF_TEMP_LOW, 8'h11);
        wr(DAT_OFF_TEMP_HIGH, 8'h33);
        rdchk(DAT_OFF_TEMP_LOW, 8'hA8);
        rdchk(DAT_OFF_TEMP_HIGH, 8'hD8);
        wr(7'h10, 8'hFF);
        rdchk(7'h10, 8'h00);
        rdchk(DAT_OFF_Q_FS_LOW, 8'hFF);
    endtask : t_temp

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        miscompares = 0;
        check_count = 0;
        rst_n = 1'b0;
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_sdi = 1'b0;
        temp_result = 16'h0000;
        temp_valid = 1'b0;
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_aux(0, DAT_OFF_I_AUX_MAG_LOW, DAT_OFF_I_AUX_CTRL);
        t_aux(1, DAT_OFF_Q_AUX_MAG_LOW, DAT_OFF_Q_AUX_CTRL);
        t_conv();
        t_meas();
        t_temp();
        conclude();
    end

    // bounded run: a hang counts against the design
    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        $display("mismatch run length expected end seen timeout");
        conclude();
    end

endmodule : tb
